// ---- pll_synth_divider_config.sv ----
// configuration latches, serial port, dividers, slowdown and observe mux of the synthesizer
//
// Local design decisions: the placing of the registers and the Avalon-MM slave port.
`timescale 1ns/1ps
`include "pll_cfg_regs.svh"

module pll_synth_divider_config #(
  parameter int M_W     = 7,
  parameter int SHIFT_W = 12
) (
  input  wire logic                clk,
  input  wire logic                rst_b,
  input  wire logic                ce,
  input  wire logic [3:0]          avs_address,
  input  wire logic                avs_read,
  input  wire logic                avs_write,
  input  wire logic [31:0]         avs_writedata,
  input  wire logic [3:0]          avs_byteenable,
  output logic      [31:0]         avs_readdata,
  output logic                     avs_waitrequest,
  input  wire logic [M_W-1:0]      loop_div_in,
  input  wire logic [1:0]          out_div_sel_in,
  input  wire logic                par_load_b,
  input  wire logic                serial_data_in,
  input  wire logic                serial_clock_in,
  input  wire logic                serial_commit_in,
  input  wire logic                slowdown_request,
  input  wire logic                out_enable_in,
  input  wire logic                reference_source_select,
  input  wire logic                external_reference_in,
  input  wire logic                crystal_pins,
  input  wire logic                vco_clk_in,
  output logic                     synth_out,
  output logic                     synth_out_b,
  output logic                     observe_out,
  output logic                     vco_faster,
  output logic                     vco_slower
);
  import pll_cfg_pkg::*;

  // pins pass two flops; reset values mirror the pullups and pulldowns
  logic [`PIN_COUNT-1:0] pin_raw;
  logic [`PIN_COUNT-1:0] pin_meta_reg;
  logic [`PIN_COUNT-1:0] pin_sync_reg;
  logic [`PIN_COUNT-1:0] pin_prev_reg;
  localparam logic [`PIN_COUNT-1:0] pin_rst_val = `PIN_RESET;

  assign pin_raw = {vco_clk_in, crystal_pins, external_reference_in, reference_source_select,
                    serial_clock_in, serial_data_in, serial_commit_in, par_load_b,
                    out_enable_in, slowdown_request, out_div_sel_in, loop_div_in};

  genvar gi;
  generate
    for (gi = 0; gi < `PIN_COUNT; gi = gi + 1)
    begin : g_sync
      always_ff @(posedge clk or negedge rst_b)
      begin
        if (!rst_b)
        begin
          pin_meta_reg[gi] <= pin_rst_val[gi];
          pin_sync_reg[gi] <= pin_rst_val[gi];
          pin_prev_reg[gi] <= pin_rst_val[gi];
        end
        else if (ce)
        begin
          pin_meta_reg[gi] <= pin_raw[gi];
          pin_sync_reg[gi] <= pin_meta_reg[gi];
          pin_prev_reg[gi] <= pin_sync_reg[gi];
        end
      end
    end
  endgenerate

  logic [M_W-1:0] m_sync;
  logic [1:0]     n_sync;
  logic           p_lvl, p_rise, sload_lvl, sdata_lvl, sclk_rise, sclk_edge;
  logic           slow_lvl, oe_lvl, ref_sel_lvl, ref_lvl, ref_prev, ref_rise;
  logic           vco_rise, vco_edge;

  assign m_sync      = pin_sync_reg[`PIN_M_LSB +: M_W];
  assign n_sync      = pin_sync_reg[`PIN_N_LSB +: 2];
  assign p_lvl       = pin_sync_reg[`PIN_PLOAD];
  assign p_rise      = p_lvl & ~pin_prev_reg[`PIN_PLOAD];
  assign sload_lvl   = pin_sync_reg[`PIN_SLOAD];
  assign sdata_lvl   = pin_sync_reg[`PIN_SDATA];
  assign sclk_rise   = pin_sync_reg[`PIN_SCLK] & ~pin_prev_reg[`PIN_SCLK];
  assign sclk_edge   = pin_sync_reg[`PIN_SCLK] ^ pin_prev_reg[`PIN_SCLK];
  assign slow_lvl    = pin_sync_reg[`PIN_SLOW];
  assign oe_lvl      = pin_sync_reg[`PIN_OE];
  assign ref_sel_lvl = pin_sync_reg[`PIN_REFSEL];
  // crystal when select high, external input when low
  assign ref_lvl  = ref_sel_lvl ? pin_sync_reg[`PIN_XTAL] : pin_sync_reg[`PIN_FREF];
  assign ref_prev = ref_sel_lvl ? pin_prev_reg[`PIN_XTAL] : pin_prev_reg[`PIN_FREF];
  // level and previous value pass the same select, so a select change cannot fake a reference edge
  assign ref_rise = ref_lvl & ~ref_prev;
  assign vco_rise = pin_sync_reg[`PIN_VCO] & ~pin_prev_reg[`PIN_VCO];
  assign vco_edge = pin_sync_reg[`PIN_VCO] ^ pin_prev_reg[`PIN_VCO];

  // serial shift register and configuration latches
  logic [SHIFT_W-1:0] shift_reg, shift_next;
  logic [M_W-1:0]     cfg_m_reg, cfg_m_next;
  logic [1:0]         cfg_n_reg, cfg_n_next;
  test_sel_t          cfg_t_reg, cfg_t_next;

  always_comb
  begin
    shift_next = shift_reg;
    if (sclk_rise)
      shift_next = {shift_reg[SHIFT_W-2:0], sdata_lvl};
    cfg_m_next = cfg_m_reg;
    cfg_n_next = cfg_n_reg;
    cfg_t_next = cfg_t_reg;
    if (!p_lvl || p_rise)
    begin
      // parallel path checked first so it always wins
      cfg_m_next = m_sync;
      cfg_n_next = n_sync;
      cfg_t_next = TST_SHIFT;
    end
    else if (sload_lvl)
    begin
      // first bits shifted end up highest: select, output divide, loop divide
      cfg_t_next = test_sel_t'(shift_reg[SHIFT_W-1 -: 3]);
      cfg_n_next = shift_reg[M_W +: 2];
      cfg_m_next = shift_reg[M_W-1:0];
    end
    // commit low: latches hold whatever shifting does
  end

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      shift_reg <= '0;
      cfg_m_reg <= `CFG_M_RESET;
      cfg_n_reg <= `CFG_N_RESET;
      cfg_t_reg <= TST_SHIFT;
    end
    else if (ce)
    begin
      shift_reg <= shift_next;
      cfg_m_reg <= cfg_m_next;
      cfg_n_reg <= cfg_n_next;
      cfg_t_reg <= cfg_t_next;
    end
  end

  // slowdown ramp, one octave step per reference edge
  logic [1:0] slow_reg, slow_next;

  always_comb
  begin
    slow_next = slow_reg;
    if (ref_rise && slow_lvl && slow_reg != `SLOW_MAX)
      slow_next = slow_reg + 2'h1;
    else if (ref_rise && !slow_lvl && slow_reg != 2'h0)
      slow_next = slow_reg - 2'h1;
  end

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
      slow_reg <= 2'h0;
    else if (ce)
      slow_reg <= slow_next;
  end

  // output divider counts half periods so every ratio keeps an even duty
  logic       bypass;
  logic       half_tick, full_tick;
  logic [1:0] n_shift;
  logic [2:0] tot_shift;
  logic [5:0] half_limit;
  logic [5:0] half_cnt_reg, half_cnt_next;
  logic       fout_reg, fout_next;
  logic [2:0] tog_cnt_reg, tog_cnt_next;

  assign bypass    = (cfg_t_reg == TST_BYPASS);
  assign half_tick = bypass ? sclk_edge : vco_edge;
  assign full_tick = bypass ? sclk_rise : vco_rise;

  always_comb
  begin
    unique case (cfg_n_reg)
      2'h3: n_shift = 2'h0;
      2'h0: n_shift = 2'h1;
      2'h1: n_shift = 2'h2;
      2'h2: n_shift = 2'h3;
    endcase
  end

  assign tot_shift  = {1'b0, n_shift} + {1'b0, slow_reg};
  assign half_limit = 6'((7'h1 << tot_shift) - 7'h1);

  always_comb
  begin
    half_cnt_next = half_cnt_reg;
    fout_next     = fout_reg;
    tog_cnt_next  = tog_cnt_reg;
    if (half_tick)
    begin
      // >= so a shrinking limit mid-count cannot overrun
      if (half_cnt_reg >= half_limit)
      begin
        half_cnt_next = 6'h0;
        fout_next     = ~fout_reg;
        tog_cnt_next  = tog_cnt_reg + 3'h1;
      end
      else
        half_cnt_next = half_cnt_reg + 6'h1;
    end
  end

  // loop divider and a simple count-based phase detector
  logic [M_W-1:0] loop_cnt_reg, loop_cnt_next;
  logic           loop_out_reg, loop_out_next;
  logic [1:0]     fb_cnt_reg, fb_cnt_next;
  logic           faster_reg, faster_next, slower_reg, slower_next;
  logic           loop_en_reg, loop_en_next;
  logic           loop_wrap;

  assign loop_wrap = full_tick && (loop_cnt_reg + M_W'(1) >= cfg_m_reg);

  always_comb
  begin
    loop_cnt_next = loop_cnt_reg;
    loop_out_next = loop_out_reg;
    fb_cnt_next   = fb_cnt_reg;
    faster_next   = faster_reg;
    slower_next   = slower_reg;
    if (full_tick)
    begin
      loop_cnt_next = loop_wrap ? '0 : loop_cnt_reg + M_W'(1);
      loop_out_next = loop_wrap;
    end
    if (loop_wrap && fb_cnt_reg != 2'h3)
      fb_cnt_next = fb_cnt_reg + 2'h1;
    if (ref_rise)
    begin
      // one loop wrap per reference period means vco equals m times reference
      faster_next = loop_en_reg && (fb_cnt_reg == 2'h0);
      slower_next = loop_en_reg && (fb_cnt_reg > 2'h1);
      fb_cnt_next = {1'b0, loop_wrap};
    end
  end

  // observe mux, registered so the pin is glitch free
  logic obs_next;
  logic out_p_next, out_n_next;

  always_comb
  begin
    unique case (cfg_t_reg)
      TST_SHIFT:     obs_next = shift_reg[SHIFT_W-1];
      TST_HIGH:      obs_next = 1'b1;
      TST_REF:       obs_next = ref_lvl;
      TST_LOOP:      obs_next = loop_out_reg;
      TST_FOUT:      obs_next = fout_reg;
      TST_LOW:       obs_next = 1'b0;
      TST_BYPASS:    obs_next = loop_out_reg;
      TST_FOUT_DIV4: obs_next = tog_cnt_reg[2];
    endcase
    out_p_next = fout_reg & oe_lvl;
    out_n_next = ~fout_reg & oe_lvl;
  end

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      half_cnt_reg <= 6'h0;
      fout_reg     <= 1'b0;
      tog_cnt_reg  <= 3'h0;
      loop_cnt_reg <= '0;
      loop_out_reg <= 1'b0;
      fb_cnt_reg   <= 2'h0;
      faster_reg   <= 1'b0;
      slower_reg   <= 1'b0;
      observe_out  <= 1'b0;
      synth_out    <= 1'b0;
      synth_out_b  <= 1'b0;
    end
    else if (ce)
    begin
      half_cnt_reg <= half_cnt_next;
      fout_reg     <= fout_next;
      tog_cnt_reg  <= tog_cnt_next;
      loop_cnt_reg <= loop_cnt_next;
      loop_out_reg <= loop_out_next;
      fb_cnt_reg   <= fb_cnt_next;
      faster_reg   <= faster_next;
      slower_reg   <= slower_next;
      observe_out  <= obs_next;
      synth_out    <= out_p_next;
      synth_out_b  <= out_n_next;
    end
  end

  assign vco_faster = faster_reg;
  assign vco_slower = slower_reg;

  // avalon slave: one wait cycle, then the answer
  logic        req, accept;
  logic        wait_reg, wait_next;
  logic [31:0] rdata_reg, rdata_next;

  assign req    = avs_read | avs_write;
  assign accept = req & ~wait_reg;

  always_comb
  begin
    wait_next    = ~(req & wait_reg);
    rdata_next   = rdata_reg;
    loop_en_next = loop_en_reg;
    if (req && wait_reg && avs_read)
    begin
      rdata_next = 32'h0;
      unique case (avs_address)
        `CTRL_OFS:  rdata_next[`CTRL_LOOP_EN] = loop_en_reg;
        `STAT_OFS:
        begin
          rdata_next[`STAT_M_LSB +: M_W]  = cfg_m_reg;
          rdata_next[`STAT_N_LSB +: 2]    = cfg_n_reg;
          rdata_next[`STAT_T_LSB +: 3]    = cfg_t_reg;
          rdata_next[`STAT_SLOW_LSB +: 2] = slow_reg;
          rdata_next[`STAT_REF_BIT]       = ref_sel_lvl;
        end
        `SHIFT_OFS: rdata_next[SHIFT_W-1:0] = shift_reg;
        default:    rdata_next = 32'h0;
      endcase
    end
    if (accept && avs_write && avs_address == `CTRL_OFS && avs_byteenable[0])
      loop_en_next = avs_writedata[`CTRL_LOOP_EN];
  end

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      wait_reg    <= 1'b1;
      rdata_reg   <= 32'h0;
      loop_en_reg <= `CTRL_RESET;
    end
    else if (ce)
    begin
      wait_reg    <= wait_next;
      rdata_reg   <= rdata_next;
      loop_en_reg <= loop_en_next;
    end
  end

  assign avs_waitrequest = wait_reg;
  assign avs_readdata    = rdata_reg;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);

  chk_par_transparent: assert property (
    (ce && !p_lvl) |=> cfg_m_reg == $past(m_sync))
    else $error("loop divide not following parallel inputs");
  chk_par_capture: assert property (
    (ce && p_rise) |=> cfg_n_reg == $past(n_sync) && cfg_m_reg == $past(m_sync))
    else $error("parallel capture missed");
  chk_par_priority: assert property (
    (ce && !p_lvl && sload_lvl) |=> cfg_n_reg == $past(n_sync))
    else $error("serial path overrode parallel path");
  chk_obs_forced: assert property (
    (ce && !p_lvl) |=> cfg_t_reg == TST_SHIFT)
    else $error("observe select not forced to zero");
  chk_shift_step: assert property (
    (ce && sclk_rise) |=> shift_reg == {$past(shift_reg[SHIFT_W-2:0]), $past(sdata_lvl)})
    else $error("shift register did not step");
  chk_serial_follow: assert property (
    (ce && p_lvl && !p_rise && sload_lvl) |=> {cfg_t_reg, cfg_n_reg, cfg_m_reg} == $past(shift_reg))
    else $error("latches not following shift register");
  chk_serial_hold: assert property (
    (ce && p_lvl && !p_rise && !sload_lvl) |=> $stable(cfg_m_reg) && $stable(cfg_t_reg))
    else $error("settings changed without commit");
  chk_slow_down: assert property (
    (ce && ref_rise && slow_lvl && slow_reg != `SLOW_MAX) |=> slow_reg == $past(slow_reg) + 2'h1)
    else $error("slowdown did not step down");
  chk_slow_up: assert property (
    (ce && ref_rise && !slow_lvl && slow_reg != 2'h0) |=> slow_reg == $past(slow_reg) - 2'h1)
    else $error("release did not step back");
  chk_out_enable: assert property (
    (ce && !oe_lvl) |=> !synth_out && !synth_out_b)
    else $error("output active while disabled");
  chk_fout_toggle: assert property (
    (ce && half_tick && half_cnt_reg >= half_limit) |=> fout_reg != $past(fout_reg))
    else $error("output divider missed its toggle");
  chk_bus_answer: assert property (
    (ce && req && wait_reg) |=> !wait_reg)
    else $error("bus answer late");

  cov_serial_commit: cover property (p_lvl ##1 sload_lvl ##1 !sload_lvl);
  cov_slow_full:     cover property (slow_reg == `SLOW_MAX);
  cov_bypass:        cover property (bypass && full_tick);
  cov_par_capture:   cover property (p_rise);
endmodule

// ---- pll_cfg_regs.svh ----
// register offsets, field positions, reset values and pin indices of the synthesizer config block
`ifndef PLL_CFG_REGS_SVH
`define PLL_CFG_REGS_SVH

`define CTRL_OFS        4'h0
`define STAT_OFS        4'h4
`define SHIFT_OFS       4'h8

`define CTRL_LOOP_EN    0
`define CTRL_RESET      1'b1

`define STAT_M_LSB      0
`define STAT_N_LSB      8
`define STAT_T_LSB      12
`define STAT_SLOW_LSB   16
`define STAT_REF_BIT    20

`define PIN_COUNT       19
`define PIN_M_LSB       0
`define PIN_N_LSB       7
`define PIN_SLOW        9
`define PIN_OE          10
`define PIN_PLOAD       11
`define PIN_SLOAD       12
`define PIN_SDATA       13
`define PIN_SCLK        14
`define PIN_REFSEL      15
`define PIN_FREF        16
`define PIN_XTAL        17
`define PIN_VCO         18
`define PIN_RESET       19'h08dff

`define SLOW_MAX        2'h3
`define CFG_M_RESET     7'h7f
`define CFG_N_RESET     2'h3

`endif

// ---- pll_cfg_pkg.sv ----
// types shared by the synthesizer configuration block
package pll_cfg_pkg;

  typedef enum logic [2:0] {
    TST_SHIFT     = 3'h0,
    TST_HIGH      = 3'h1,
    TST_REF       = 3'h2,
    TST_LOOP      = 3'h3,
    TST_FOUT      = 3'h4,
    TST_LOW       = 3'h5,
    TST_BYPASS    = 3'h6,
    TST_FOUT_DIV4 = 3'h7
  } test_sel_t;

endpackage

// ---- pll_cfg_ctrl_model.sv ----
// system controller model: parallel pins, serial port, vco and reference sources
`timescale 1ns/1ps
module pll_cfg_ctrl_model (
  input  wire logic       clk,
  output logic      [6:0] loop_div_in,
  output logic      [1:0] out_div_sel_in,
  output logic            par_load_b,
  output logic            serial_data_in,
  output logic            serial_clock_in,
  output logic            serial_commit_in,
  output logic            external_reference_in,
  output logic            crystal_pins,
  output logic            vco_clk_in
);
  logic       ext_run;
  logic [7:0] tick;

  initial
  begin
    loop_div_in      = 7'h7f;
    out_div_sel_in   = 2'h3;
    par_load_b       = 1'b0;   // held low through reset
    serial_data_in   = 1'b0;
    serial_clock_in  = 1'b0;
    serial_commit_in = 1'b0;
    ext_run          = 1'b1;
    tick             = 8'h00;
  end

  // free sources kept slow: the block sees pins through synchronisers
  always @(posedge clk)
    tick <= tick + 8'h01;
  assign vco_clk_in            = tick[2];
  assign crystal_pins          = tick[4];
  assign external_reference_in = ext_run & tick[3];

  // mode 0 strobe low, 1 capture, 2 pins only
  task automatic par_set(input logic [6:0] m, input logic [1:0] n, input int mode);
    @(posedge clk);
    loop_div_in    <= m;
    out_div_sel_in <= n;
    if (mode != 2)
      par_load_b <= 1'b0;
    if (mode == 1)
    begin
      repeat (6) @(posedge clk);
      par_load_b <= 1'b1;   // pins left alone across the rise
      repeat (6) @(posedge clk);
    end
  endtask

  task automatic shift(input int nb, input logic [15:0] v);
    for (int i = nb - 1; i >= 0; i--)
    begin
      @(posedge clk);
      serial_data_in <= v[i];   // msb of each field first
      repeat (4) @(posedge clk);
      serial_clock_in <= 1'b1;
      repeat (4) @(posedge clk);
      serial_clock_in <= 1'b0;
    end
    repeat (4) @(posedge clk);
    serial_data_in <= 1'b0;   // released line falls to its pulldown
  endtask

  task automatic commit();
    @(posedge clk);
    serial_commit_in <= 1'b1;
    repeat (6) @(posedge clk);
    serial_commit_in <= 1'b0;   // shift data untouched across the fall
    repeat (6) @(posedge clk);
  endtask
endmodule

// ---- test_pll_synth_divider_config.sv ----
// self-checking bench of the synthesizer configuration block
`timescale 1ns/1ps
`include "pll_cfg_regs.svh"
module test_pll_synth_divider_config;
  import pll_cfg_pkg::*;
  logic        clk = 1'b0;
  logic        rst_b, avs_read, avs_write, avs_waitrequest;
  logic [3:0]  avs_address, avs_byteenable;
  logic [31:0] avs_writedata, avs_readdata;
  logic [6:0]  loop_div_in, m;
  logic [1:0]  out_div_sel_in, n;
  logic        par_load_b, serial_data_in, serial_clock_in, serial_commit_in;
  logic        slowdown_request, out_enable_in, reference_source_select;
  logic        external_reference_in, crystal_pins, vco_clk_in;
  logic        synth_out, synth_out_b, observe_out, vco_faster, vco_slower;
  logic [31:0] exp_q[$];
  logic [1:0]  ncode[4] = '{2'h3, 2'h0, 2'h1, 2'h2};
  logic        so_last = 1'b0;
  logic        ramp_on = 1'b0;
  int          run_len = 0;
  int          prev_len = 0;
  int          bad_count = 0;
  int          compares = 0;
  int          seed, hi;

  pll_synth_divider_config i_dut (.clk(clk), .rst_b(rst_b), .ce(1'b1),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .loop_div_in(loop_div_in), .out_div_sel_in(out_div_sel_in), .par_load_b(par_load_b),
    .serial_data_in(serial_data_in), .serial_clock_in(serial_clock_in),
    .serial_commit_in(serial_commit_in), .slowdown_request(slowdown_request),
    .out_enable_in(out_enable_in), .reference_source_select(reference_source_select),
    .external_reference_in(external_reference_in), .crystal_pins(crystal_pins),
    .vco_clk_in(vco_clk_in), .synth_out(synth_out), .synth_out_b(synth_out_b),
    .observe_out(observe_out), .vco_faster(vco_faster), .vco_slower(vco_slower));

  pll_cfg_ctrl_model i_ctrl (.clk(clk), .loop_div_in(loop_div_in),
    .out_div_sel_in(out_div_sel_in), .par_load_b(par_load_b),
    .serial_data_in(serial_data_in), .serial_clock_in(serial_clock_in),
    .serial_commit_in(serial_commit_in), .external_reference_in(external_reference_in),
    .crystal_pins(crystal_pins), .vco_clk_in(vco_clk_in));

  initial
  begin
    forever #12.5 clk = ~clk;
  end

  task automatic give_verdict();
    $display("compares=%0d bad_count=%0d", compares, bad_count);
    if (bad_count == 0 && compares > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp)
    begin
      bad_count++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic chk_rng(input int got, input int lo, input int hi);
    compares++;
    if (got < lo || got > hi)
    begin
      bad_count++;
      $display("FAIL t=%0t got=%h exp=%h..%h", $time, got, lo, hi);
    end
  endtask

  // one request held until the edge that samples waitrequest low
  task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d,
                     input logic [3:0] be);
    @(posedge clk);
    avs_address    <= a;
    avs_read       <= !wr;
    avs_write      <= wr;
    avs_writedata  <= d;
    avs_byteenable <= be;
    if (!wr)
      exp_q.push_back(d);
    // no cycle count assumed: only the watchdog ends this wait
    do
    begin
      @(posedge clk);
    end
    while (avs_waitrequest !== 1'b0);
    avs_read  <= 1'b0;
    avs_write <= 1'b0;
  endtask

  task automatic rd(input logic [3:0] a, input logic [31:0] e);
    bus(1'b0, a, e, 4'hf);
  endtask

  function automatic logic [31:0] stat(input logic [6:0] sm, input logic [1:0] sn,
                                       input logic [2:0] ss, input logic [1:0] sl,
                                       input logic r);
    stat = 32'h0;
    stat[`STAT_M_LSB +: 7]    = sm;
    stat[`STAT_N_LSB +: 2]    = sn;
    stat[`STAT_T_LSB +: 3]    = ss;
    stat[`STAT_SLOW_LSB +: 2] = sl;
    stat[`STAT_REF_BIT]       = r;
  endfunction

  // toggles and high time over a fixed window, vco half period is 4 clk
  task automatic measure(input int div);
    int tg, h;
    logic last;
    tg = 0;
    h = 0;
    @(posedge clk);
    last = synth_out;
    repeat (512)
    begin
      @(posedge clk);
      if (synth_out !== last)
        tg++;
      if (synth_out === 1'b1)
        h++;
      last = synth_out;
      chk({31'h0, synth_out_b}, {31'h0, ~synth_out});
    end
    chk_rng(tg, 128 / div - 1, 128 / div + 1);
    chk_rng(h, 256 - 4 * div, 256 + 4 * div);
  endtask

  always @(posedge clk)
    if (avs_read === 1'b1 && avs_waitrequest === 1'b0)
      chk(avs_readdata, exp_q.pop_front());

  // a ramp never more than doubles or halves one half period
  always @(posedge clk)
  begin
    if (synth_out !== so_last)
    begin
      if (ramp_on && prev_len != 0)
        chk_rng(run_len, prev_len / 2 - 2, 2 * prev_len + 2);
      prev_len = run_len;
      run_len = 1;
    end
    else
      run_len++;
    so_last = synth_out;
  end

  initial
  begin
    repeat (40000) @(posedge clk);
    bad_count++;
    give_verdict();
  end

  initial
  begin
    seed = 6632;
    rst_b = 1'b0;
    avs_address = 4'h0;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = 32'h0;
    avs_byteenable = 4'h0;
    slowdown_request = 1'b0;
    out_enable_in = 1'b1;
    reference_source_select = 1'b1;
    repeat (20) @(posedge clk);
    rst_b <= 1'b1;
    repeat (8) @(posedge clk);
    rd(`STAT_OFS, stat(7'h7f, 2'h3, 3'h0, 2'h0, 1'b1));
    rd(`CTRL_OFS, 32'h1);
    rd(`SHIFT_OFS, 32'h0);
    rd(4'hc, 32'h0);
    bus(1'b1, `CTRL_OFS, 32'h0, 4'h2);
    rd(`CTRL_OFS, 32'h1);
    bus(1'b1, `CTRL_OFS, 32'h0, 4'h1);
    rd(`CTRL_OFS, 32'h0);
    repeat (100) @(posedge clk);
    chk({30'h0, vco_faster, vco_slower}, 32'h0);
    bus(1'b1, `STAT_OFS, 32'h0, 4'hf);
    bus(1'b1, `CTRL_OFS, 32'h1, 4'hf);
    i_ctrl.par_set(7'h01, 2'h3, 0);
    repeat (120) @(posedge clk);
    chk({30'h0, vco_faster, vco_slower}, 32'h1);
    i_ctrl.par_set(7'h7f, 2'h3, 0);
    repeat (120) @(posedge clk);
    chk({30'h0, vco_faster, vco_slower}, 32'h2);
    for (int i = 0; i < 4; i++)
    begin
      i_ctrl.par_set(7'h20, ncode[i], 0);
      repeat (64) @(posedge clk);
      measure(1 << i);
    end
    for (int i = 0; i < 4; i++)
    begin
      m = 7'($random(seed));
      n = 2'($random(seed));
      i_ctrl.par_set(m, n, 0);
      repeat (8) @(posedge clk);
      rd(`STAT_OFS, stat(m, n, 3'h0, 2'h0, 1'b1));
      i_ctrl.par_set(m, n, 1);
      i_ctrl.par_set(~m, ~n, 2);
      repeat (8) @(posedge clk);
      rd(`STAT_OFS, stat(m, n, 3'h0, 2'h0, 1'b1));
    end
    // strobe stays high for every serial load but the last, which commits with it low
    i_ctrl.par_set(7'h30, 2'h3, 1);
    i_ctrl.shift(13, {4'h1, TST_HIGH, 2'h0, 7'h2a});
    rd(`SHIFT_OFS, 32'h22a);
    rd(`STAT_OFS, stat(7'h30, 2'h3, 3'h0, 2'h0, 1'b1));
    i_ctrl.commit();
    rd(`STAT_OFS, stat(7'h2a, 2'h0, TST_HIGH, 2'h0, 1'b1));
    chk({31'h0, observe_out}, 32'h1);
    m = 7'($random(seed));
    i_ctrl.shift(12, {4'h0, TST_LOW, 2'h3, m});
    i_ctrl.commit();
    rd(`STAT_OFS, stat(m, 2'h3, TST_LOW, 2'h0, 1'b1));
    chk({31'h0, observe_out}, 32'h0);
    i_ctrl.shift(12, {4'h0, TST_FOUT, 2'h3, 7'h20});
    i_ctrl.commit();
    repeat (64)
    begin
      @(posedge clk);
      chk({31'h0, observe_out}, {31'h0, synth_out});
    end
    // bypass at divide by two: vco ignored, one serial clock pulse toggles the output
    i_ctrl.shift(12, {4'h0, TST_BYPASS, 2'h0, 7'h20});
    i_ctrl.commit();
    hi = synth_out;
    repeat (64) @(posedge clk);
    chk({31'h0, synth_out}, {31'h0, hi[0]});
    i_ctrl.shift(1, 16'h0);
    repeat (4) @(posedge clk);
    chk({31'h0, synth_out}, {31'h0, ~hi[0]});
    i_ctrl.shift(12, {4'h0, TST_HIGH, 2'h1, 7'h11});
    i_ctrl.par_set(7'h44, 2'h1, 0);
    i_ctrl.commit();
    rd(`STAT_OFS, stat(7'h44, 2'h1, 3'h0, 2'h0, 1'b1));
    i_ctrl.par_set(7'h20, 2'h3, 1);
    out_enable_in <= 1'b0;
    repeat (8) @(posedge clk);
    hi = 0;
    repeat (64)
    begin
      @(posedge clk);
      if (synth_out !== 1'b0 || synth_out_b !== 1'b0)
        hi++;
    end
    chk_rng(hi, 0, 0);
    out_enable_in <= 1'b1;
    repeat (64) @(posedge clk);
    ramp_on <= 1'b1;
    slowdown_request <= 1'b1;
    repeat (250) @(posedge clk);
    rd(`STAT_OFS, stat(7'h20, 2'h3, 3'h0, 2'h3, 1'b1));
    measure(8);
    slowdown_request <= 1'b0;
    repeat (250) @(posedge clk);
    rd(`STAT_OFS, stat(7'h20, 2'h3, 3'h0, 2'h0, 1'b1));
    measure(1);
    ramp_on <= 1'b0;
    i_ctrl.ext_run <= 1'b0;
    reference_source_select <= 1'b0;
    repeat (16) @(posedge clk);
    slowdown_request <= 1'b1;
    repeat (250) @(posedge clk);
    rd(`STAT_OFS, stat(7'h20, 2'h3, 3'h0, 2'h0, 1'b0));
    slowdown_request <= 1'b0;
    give_verdict();
  end
endmodule
